// *** src/iil_issue_interlock.sv ***
// Issue latency and result interlock for a single-issue pipeline
`timescale 1ns/1ps
`default_nettype none
module iil_issue_interlock (
    input wire logic clock,
    input wire logic rst,
    input wire logic candValid,
    input wire iil_pkg::iil_op_t candOp,
    input wire logic candSetFlags,
    input wire logic candRegShift,
    input wire logic candTaken,
    input wire logic candBtbHit,
    input wire logic candBtbTaken,
    input wire logic [4:0] candNumReg,
    input wire logic [31:0] candMulOperand,
    input wire logic candDstLoValid,
    input wire logic [3:0] candDstLo,
    input wire logic candDstHiValid,
    input wire logic [3:0] candDstHi,
    input wire logic candSrcAValid,
    input wire logic [3:0] candSrcA,
    input wire logic candSrcBValid,
    input wire logic [3:0] candSrcB,
    input wire logic candSrcSValid,
    input wire logic [3:0] candSrcS,
    output logic issue,
    output logic stall,
    output logic mispredict,
    output logic btbAllocate
);
    import iil_pkg::*;

    iil_state_t st_ff;
    iil_state_t nxt_st;

    logic [LAT_W-1:0] latIssue;
    logic [CNT_W-1:0] latLo;
    logic [CNT_W-1:0] latHi;
    logic [CNT_W-1:0] latRes;
    logic [CNT_W-1:0] cls;
    logic extra;
    logic isMul;
    logic writesAcc;
    logic readsAcc;
    logic mispred;
    logic alloc;
    logic depOk;
    logic decide;
    logic [NREG-1:0] sbLoad;
    logic [CNT_W-1:0] sbLoadCnt [NREG];
    logic [CNT_W-1:0] sbCnt [NREG];
    logic [NREG-1:0] readyN;
    logic [NREG-1:0] readyS;

    // ==========================================================
    // Operand class, uniform high bits end the multiply early
    always_comb begin
        if (&candMulOperand[OPND_MSB:FAST_LSB] || ~|candMulOperand[OPND_MSB:FAST_LSB]) begin
            cls = CNT_ZERO;
        end else if (&candMulOperand[OPND_MSB:MID_LSB]
                || ~|candMulOperand[OPND_MSB:MID_LSB]) begin
            cls = CNT_ONE;
        end else begin
            cls = CNT_TWO;
        end
    end

    // ==========================================================
    // Latency table per class
    always_comb begin
        latIssue = LAT_ONE;
        latLo = CNT_ONE;
        latHi = CNT_ONE;
        latRes = CNT_ZERO;
        extra = 1'b0;
        isMul = 1'b0;
        writesAcc = 1'b0;
        readsAcc = 1'b0;
        mispred = 1'b0;
        alloc = 1'b0;
        case (candOp)
            OP_ALU, OP_ALU_PC: begin
                latIssue = candRegShift ? LAT_TWO : LAT_ONE;
                latLo = candRegShift ? CNT_TWO : CNT_ONE;
                extra = 1'b1;
                if (candOp == OP_ALU_PC && candTaken) begin
                    latIssue = latIssue + BR_PENALTY;
                    mispred = 1'b1;
                end
            end
            OP_BRANCH: begin
                // Not in the buffer means predicted not taken
                mispred = candBtbHit ? (candBtbTaken != candTaken) : candTaken;
                alloc = candTaken && !candBtbHit;
                latIssue = mispred ? LAT_ONE + BR_PENALTY : LAT_ONE;
            end
            OP_BX: begin
                latIssue = candTaken ? BX_TAKEN : LAT_ONE;
                mispred = candTaken;
            end
            OP_BLX_IMM: begin
                latIssue = BX_TAKEN;
                mispred = 1'b1;
            end
            OP_LDR_PC: begin
                latIssue = candTaken ? LDR_PC_T : LDR_PC_NT;
                mispred = candTaken;
            end
            OP_LDM_PC: begin
                if (candTaken) begin
                    latIssue = (candNumReg > LDM_PC_FREE)
                        ? LDM_PC_T_BASE + candNumReg - LDM_PC_FREE
                        : LDM_PC_T_BASE;
                end else begin
                    latIssue = LDM_PC_NT_BASE + candNumReg;
                end
                mispred = candTaken;
            end
            OP_MUL: begin
                isMul = 1'b1;
                extra = 1'b1;
                latLo = CNT_TWO + cls;
                latRes = candSetFlags ? CNT_TWO + cls : CNT_ONE + cls;
                latIssue = candSetFlags ? LAT_TWO + 5'(cls) : LAT_ONE;
            end
            OP_MULL, OP_MLAL: begin
                isMul = 1'b1;
                extra = 1'b1;
                if (candSetFlags) begin
                    latIssue = LAT_THREE + 5'(cls);
                    latLo = CNT_THREE + cls;
                    latHi = CNT_THREE + cls;
                    latRes = CNT_THREE + cls;
                end else begin
                    latIssue = (candOp == OP_MLAL) ? LAT_TWO : LAT_ONE;
                    latLo = CNT_TWO + cls;
                    latHi = CNT_THREE + cls;
                    latRes = CNT_TWO + cls;
                end
            end
            OP_MUL_HH: begin
                isMul = 1'b1;
                extra = 1'b1;
                latLo = CNT_TWO;
                latRes = CNT_ONE;
            end
            OP_MUL_WH: begin
                isMul = 1'b1;
                extra = 1'b1;
                latLo = CNT_THREE;
                latRes = CNT_TWO;
            end
            OP_MLAL_HH: begin
                isMul = 1'b1;
                extra = 1'b1;
                latIssue = LAT_TWO;
                latLo = CNT_TWO;
                latHi = CNT_THREE;
                latRes = CNT_TWO;
            end
            OP_ACC_MUL: begin
                isMul = 1'b1;
                writesAcc = 1'b1;
                // Issue stays at one cycle; only result and resource grow with class
                latLo = CNT_ONE + cls;
                latRes = CNT_ONE + cls;
            end
            OP_ACC_MUL_HH: begin
                isMul = 1'b1;
                writesAcc = 1'b1;
                latLo = CNT_ONE;
                latRes = CNT_ONE;
            end
            OP_ACC_MUL_PH: begin
                isMul = 1'b1;
                writesAcc = 1'b1;
                latLo = CNT_TWO;
                latRes = CNT_TWO;
            end
            OP_MOVE_TO_ACC: begin
                isMul = 1'b1;
                writesAcc = 1'b1;
                latIssue = LAT_TWO;
                latLo = CNT_TWO;
                latRes = CNT_TWO;
            end
            OP_MOVE_FROM_ACC: begin
                isMul = 1'b1;
                readsAcc = 1'b1;
                extra = 1'b1;
                latLo = CNT_TWO;
                latHi = CNT_THREE;
                latRes = CNT_TWO;
            end
            OP_SAT: begin
                latLo = CNT_TWO;
            end
            default: begin
                latIssue = LAT_ONE;
            end
        endcase
    end

    // ==========================================================
    // Scoreboard, entry 16 tracks the internal accumulator
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_sb
            iil_sb_entry u_entry (
                .clock(clock),
                .rst(rst),
                .load(sbLoad[gi]),
                .loadCnt(sbLoadCnt[gi]),
                .loadExtra(extra),
                .cnt(sbCnt[gi]),
                .readyNormal(readyN[gi]),
                .readySpecial(readyS[gi])
            );
        end
    endgenerate

    // Hi written after lo so a shared index keeps the later result
    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            sbLoad[i] = 1'b0;
            sbLoadCnt[i] = latLo;
            if (decide && candDstLoValid && {1'b0, candDstLo} == IDX_W'(i)) begin
                sbLoad[i] = 1'b1;
            end
            if (decide && candDstHiValid && {1'b0, candDstHi} == IDX_W'(i)) begin
                sbLoad[i] = 1'b1;
                sbLoadCnt[i] = latHi;
            end
            if (decide && writesAcc && ACC_IDX == IDX_W'(i)) begin
                sbLoad[i] = 1'b1;
            end
        end
    end

    // ==========================================================
    // Issue decision, made one cycle ahead of the issue clock
    always_comb begin
        depOk = (!candSrcAValid || readyN[{1'b0, candSrcA}])
            && (!candSrcBValid || readyN[{1'b0, candSrcB}])
            && (!candSrcSValid || readyS[{1'b0, candSrcS}])
            && (!readsAcc || readyN[ACC_IDX]);
        decide = candValid && (st_ff.gap == LAT_ZERO) && depOk
            && (!isMul || st_ff.res == CNT_ZERO);
    end

    // Counters hold latency minus one, reaching zero at the next legal decision
    always_comb begin
        nxt_st = st_ff;
        nxt_st.issue = decide;
        nxt_st.stall = candValid && !decide;
        nxt_st.mispred = decide && mispred;
        nxt_st.btbAlloc = decide && alloc;
        if (st_ff.gap != LAT_ZERO) begin
            nxt_st.gap = st_ff.gap - LAT_ONE;
        end
        if (st_ff.res != CNT_ZERO) begin
            nxt_st.res = st_ff.res - CNT_ONE;
        end
        if (decide) begin
            nxt_st.gap = latIssue - LAT_ONE;
            nxt_st.lastLat = latIssue;
            if (isMul) begin
                nxt_st.res = latRes - CNT_ONE;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff <= ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign issue = st_ff.issue;
    assign stall = st_ff.stall;
    assign mispredict = st_ff.mispred;
    assign btbAllocate = st_ff.btbAlloc;

    // ==========================================================
    // Checks
    sequence s_quiet4;
        !decide [*4];
    endsequence

    property p_mispred_gap;
        @(posedge clock) disable iff (rst)
        decide && candOp == OP_BRANCH && mispred |=> s_quiet4;
    endproperty
    a_mispred_gap: assert property (p_mispred_gap) else $error("branch penalty short");

    property p_pred_gap;
        @(posedge clock) disable iff (rst)
        decide && candOp == OP_BRANCH && !mispred |=> st_ff.gap == LAT_ZERO;
    endproperty
    a_pred_gap: assert property (p_pred_gap) else $error("predicted branch gap wrong");

    property p_ldm_taken;
        @(posedge clock) disable iff (rst)
        decide && candOp == OP_LDM_PC && candTaken && candNumReg == 5'h05
            |=> st_ff.gap == 5'h0B;
    endproperty
    a_ldm_taken: assert property (p_ldm_taken) else $error("load-multiple gap wrong");

    property p_fast_class;
        @(posedge clock) disable iff (rst)
        candMulOperand[31:15] == 17'h1FFFF |-> cls == CNT_ZERO;
    endproperty
    a_fast_class: assert property (p_fast_class) else $error("operand class wrong");

    property p_mul_res;
        @(posedge clock) disable iff (rst)
        decide && candOp == OP_MUL && !candSetFlags && cls == CNT_TWO
            |=> (!decide || !isMul) [*2];
    endproperty
    a_mul_res: assert property (p_mul_res) else $error("multiply issued too soon");

    property p_dep_stall;
        @(posedge clock) disable iff (rst)
        candValid && candSrcAValid && !readyN[{1'b0, candSrcA}] |=> stall && !issue;
    endproperty
    a_dep_stall: assert property (p_dep_stall) else $error("dependent not stalled");

    property p_sat_result;
        @(posedge clock) disable iff (rst)
        decide && candOp == OP_SAT && candDstLoValid
            |=> sbCnt[{1'b0, $past(candDstLo)}] == CNT_TWO;
    endproperty
    a_sat_result: assert property (p_sat_result) else $error("saturate result wrong");

    property p_alloc;
        @(posedge clock) disable iff (rst)
        decide && candOp == OP_BRANCH && candTaken && !candBtbHit |=> btbAllocate && mispredict;
    endproperty
    a_alloc: assert property (p_alloc) else $error("buffer entry missed");

    property p_alu_pc;
        @(posedge clock) disable iff (rst)
        decide && candOp == OP_ALU_PC && candTaken && !candRegShift
            |=> issue && st_ff.lastLat == 5'h05;
    endproperty
    a_alu_pc: assert property (p_alu_pc) else $error("pc write gap wrong");
endmodule : iil_issue_interlock
`default_nettype wire

// *** src/iil_pkg.sv ***
// Shared types and latency constants for the issue interlock
package iil_pkg;

    // ==========================================================
    // Widths
    localparam int LAT_W = 5;
    localparam int CNT_W = 3;
    localparam int NREG = 17;
    localparam int IDX_W = 5;
    localparam logic [IDX_W-1:0] ACC_IDX = 5'h10;

    // ==========================================================
    // Instruction classes seen at decode
    typedef enum logic [4:0] {
        OP_OTHER = 5'h00,
        OP_ALU = 5'h01,
        OP_ALU_PC = 5'h02,
        OP_BRANCH = 5'h03,
        OP_BX = 5'h04,
        OP_BLX_IMM = 5'h05,
        OP_LDR_PC = 5'h06,
        OP_LDM_PC = 5'h07,
        OP_MUL = 5'h08,
        OP_MULL = 5'h09,
        OP_MLAL = 5'h0A,
        OP_MUL_HH = 5'h0B,
        OP_MUL_WH = 5'h0C,
        OP_MLAL_HH = 5'h0D,
        OP_ACC_MUL = 5'h0E,
        OP_ACC_MUL_HH = 5'h0F,
        OP_ACC_MUL_PH = 5'h10,
        OP_MOVE_TO_ACC = 5'h11,
        OP_MOVE_FROM_ACC = 5'h12,
        OP_SAT = 5'h13
    } iil_op_t;

    // ==========================================================
    // Latency figures in core cycles
    localparam logic [LAT_W-1:0] LAT_ONE = 5'h01;
    localparam logic [LAT_W-1:0] LAT_TWO = 5'h02;
    localparam logic [LAT_W-1:0] LAT_THREE = 5'h03;
    localparam logic [LAT_W-1:0] BR_PENALTY = 5'h04;
    localparam logic [LAT_W-1:0] BX_TAKEN = 5'h05;
    localparam logic [LAT_W-1:0] LDR_PC_NT = 5'h02;
    localparam logic [LAT_W-1:0] LDR_PC_T = 5'h08;
    localparam logic [LAT_W-1:0] LDM_PC_NT_BASE = 5'h03;
    localparam logic [LAT_W-1:0] LDM_PC_T_BASE = 5'h0A;
    localparam logic [LAT_W-1:0] LDM_PC_FREE = 5'h03;
    localparam logic [LAT_W-1:0] LAT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
    localparam logic [CNT_W-1:0] CNT_TWO = 3'h2;
    localparam logic [CNT_W-1:0] CNT_THREE = 3'h3;

    // ==========================================================
    // Multiplier operand early-termination bounds
    localparam int OPND_MSB = 31;
    localparam int FAST_LSB = 15;
    localparam int MID_LSB = 27;

    // ==========================================================
    // State records
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic extra;
    } iil_sb_t;

    typedef struct packed {
        logic [LAT_W-1:0] gap;
        logic [CNT_W-1:0] res;
        logic issue;
        logic stall;
        logic mispred;
        logic btbAlloc;
        logic [LAT_W-1:0] lastLat;
    } iil_state_t;

    localparam iil_sb_t SB_RESET = '0;
    localparam iil_state_t ST_RESET = '0;

endpackage : iil_pkg

// *** src/iil_sb_entry.sv ***
// One scoreboard entry: result-ready countdown for a register
`timescale 1ns/1ps
`default_nettype none
module iil_sb_entry (
    input wire logic clock,
    input wire logic rst,
    input wire logic load,
    input wire logic [iil_pkg::CNT_W-1:0] loadCnt,
    input wire logic loadExtra,
    output logic [iil_pkg::CNT_W-1:0] cnt,
    output logic readyNormal,
    output logic readySpecial
);
    import iil_pkg::*;

    iil_sb_t sb_ff;
    iil_sb_t nxt_sb;

    // ==========================================================
    // Countdown, a new producer overrides the old one
    always_comb begin
        nxt_sb = sb_ff;
        if (load) begin
            nxt_sb.cnt = loadCnt;
            nxt_sb.extra = loadExtra;
        end else if (sb_ff.cnt != CNT_ZERO) begin
            nxt_sb.cnt = sb_ff.cnt - CNT_ONE;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sb_ff <= SB_RESET;
        end else begin
            sb_ff <= nxt_sb;
        end
    end

    // ==========================================================
    // Shift and doubled operands wait one cycle more
    assign cnt = sb_ff.cnt;
    assign readyNormal = (sb_ff.cnt <= CNT_ONE);
    assign readySpecial = sb_ff.extra ? (sb_ff.cnt == CNT_ZERO) : readyNormal;

    // ==========================================================
    // Checks
    property p_sb_wait;
        @(posedge clock) disable iff (rst)
        (load && loadCnt == CNT_THREE) ##1 !load |-> !readyNormal;
    endproperty
    a_sb_wait: assert property (p_sb_wait) else $error("entry ready too early");
endmodule : iil_sb_entry
`default_nettype wire

// *** bench/iil_issue_interlock_test.sv ***
// Self-checking bench for the issue latency interlock
`timescale 1ns/1ps
`default_nettype none
module iil_issue_interlock_test;
    import iil_pkg::*;
    // ==========================================================
    // Candidate record; bit 4 of a register field marks it valid
    typedef struct packed {
        iil_op_t op;
        logic sf, rs, tk, hit, pt;
        logic [4:0] nr;
        logic [31:0] mo;
        logic [4:0] dlo, dhi, sa, ss, sb;
    } iil_cand_t;
    localparam logic [4:0] N = 5'h00, R3 = 5'h13, R4 = 5'h14, R5 = 5'h15, R6 = 5'h16, R7 = 5'h17;

    // ==========================================================
    // Clock, stimulus and bookkeeping
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic candValid = 1'b0;
    iil_cand_t cur = '0;
    iil_cand_t ca, cb;
    logic issue, stall, mispredict, btbAllocate;
    int cyc = 0;
    int n_mismatch = 0;
    int compares = 0;
    integer seed = 66951;
    logic [31:0] mops [5] = '{32'h00007FFF, 32'hFFFF8000, 32'h00008000, 32'hF8000000,
        32'h08000000};
    // Clock at 125 MHz and a cycle count for distances
    always #4 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    // Sources A and B wait on plain results, S on the extra-cycle path
    iil_issue_interlock dut (
        .clock(clock), .rst(rst), .candValid(candValid), .candOp(cur.op),
        .candSetFlags(cur.sf), .candRegShift(cur.rs), .candTaken(cur.tk),
        .candBtbHit(cur.hit), .candBtbTaken(cur.pt), .candNumReg(cur.nr),
        .candMulOperand(cur.mo), .candDstLoValid(cur.dlo[4]), .candDstLo(cur.dlo[3:0]),
        .candDstHiValid(cur.dhi[4]), .candDstHi(cur.dhi[3:0]), .candSrcAValid(cur.sa[4]),
        .candSrcA(cur.sa[3:0]), .candSrcBValid(cur.sb[4]), .candSrcB(cur.sb[3:0]),
        .candSrcSValid(cur.ss[4]), .candSrcS(cur.ss[3:0]), .issue(issue), .stall(stall),
        .mispredict(mispredict), .btbAllocate(btbAllocate)
    );

    // ==========================================================
    // Expected timing
    function automatic int cls(logic [31:0] m);
        if (&m[31:15] || !(|m[31:15])) return 0;
        if (&m[31:27] || !(|m[31:27])) return 1;
        return 2;
    endfunction : cls

    function automatic logic misp(iil_cand_t c);
        if (c.op == OP_BRANCH) return c.hit ? c.pt != c.tk : c.tk;
        return c.tk && c.op inside {OP_ALU_PC, OP_BX, OP_BLX_IMM, OP_LDR_PC, OP_LDM_PC};
    endfunction : misp

    function automatic int iss(iil_cand_t c);
        int k;
        k = cls(c.mo);
        case (c.op)
            OP_ALU: return c.rs ? 2 : 1;
            OP_ALU_PC: return (c.rs ? 2 : 1) + (c.tk ? 4 : 0);
            OP_BRANCH: return misp(c) ? 5 : 1;
            OP_BX, OP_BLX_IMM: return c.tk ? 5 : 1;
            OP_LDR_PC: return c.tk ? 8 : 2;
            OP_LDM_PC: return c.tk ? 10 + ((c.nr > 3) ? int'(c.nr) - 3 : 0) : 3 + int'(c.nr);
            OP_MUL: return c.sf ? 2 + k : 1;
            OP_MULL: return c.sf ? 3 + k : 1;
            OP_MLAL: return c.sf ? 3 + k : 2;
            OP_MLAL_HH, OP_MOVE_TO_ACC: return 2;
            default: return 1;
        endcase
    endfunction : iss

    function automatic int rsc(iil_cand_t c);
        int k;
        k = cls(c.mo);
        case (c.op)
            OP_MUL: return c.sf ? 2 + k : 1 + k;
            OP_MULL, OP_MLAL: return c.sf ? 3 + k : 2 + k;
            OP_MUL_HH, OP_ACC_MUL_HH: return 1;
            OP_ACC_MUL: return 1 + k;
            default: return 2;
        endcase
    endfunction : rsc

    function automatic int res(iil_cand_t c, int hi);
        int k;
        k = cls(c.mo);
        case (c.op)
            OP_ALU: return c.rs ? 2 : 1;
            OP_MUL: return 2 + k;
            OP_MULL, OP_MLAL: return c.sf ? 3 + k : 2 + k + hi;
            OP_MUL_WH: return 3;
            OP_MLAL_HH, OP_MOVE_FROM_ACC: return 2 + hi;
            OP_ACC_MUL: return 1 + k;
            OP_ACC_MUL_HH: return 1;
            default: return 2;
        endcase
    endfunction : res

    // Wait owed by one source; high result wins when both halves match
    function automatic int dep(iil_cand_t a, logic [4:0] s, logic sp);
        int r;
        r = 0;
        if (s[4] && a.dlo === s) r = res(a, 0);
        if (s[4] && a.dhi === s) r = res(a, 1);
        if (r > 0 && sp && a.op inside {OP_ALU, [OP_MUL:OP_MLAL_HH], OP_MOVE_FROM_ACC}) r++;
        return r;
    endfunction : dep

    function automatic int mx(int x, int y);
        return x > y ? x : y;
    endfunction : mx

    function automatic int expDist(iil_cand_t a, iil_cand_t b);
        int d;
        d = mx(mx(iss(a), dep(a, b.sb, 1'b0)), mx(dep(a, b.sa, 1'b0), dep(a, b.ss, 1'b1)));
        if (a.op inside {[OP_MUL:OP_MOVE_FROM_ACC]} && b.op inside {[OP_MUL:OP_MOVE_FROM_ACC]})
            d = mx(d, rsc(a));
        if (a.op inside {[OP_ACC_MUL:OP_MOVE_TO_ACC]} && b.op == OP_MOVE_FROM_ACC)
            d = mx(d, res(a, 0));
        return d;
    endfunction : expDist

    // ==========================================================
    // Candidate builders
    function automatic iil_cand_t brc(iil_op_t op, logic tk, logic hit = 1'b0,
            logic pt = 1'b0, logic [4:0] nr = 5'h01);
        return '{op, 1'b0, 1'b0, tk, hit, pt, nr, 32'h0, N, N, N, N, N};
    endfunction : brc

    function automatic iil_cand_t mk(iil_op_t op, logic [4:0] dlo = N, logic [4:0] sa = N,
            logic [4:0] ss = N, logic rs = 1'b0, logic [31:0] mo = 32'h0, logic sf = 1'b0,
            logic [4:0] dhi = N);
        return '{op, sf, rs, 1'b0, 1'b0, 1'b0, 5'h01, mo, dlo, dhi, sa, ss, N};
    endfunction : mk

    // Random candidate; flag, shift and taken bits only where they mean something
    function automatic iil_cand_t rnd();
        iil_cand_t c;
        logic [31:0] r;
        r = $random(seed);
        c.op = iil_op_t'(r[4:0] % 5'h13 + 5'h01);
        c.sf = r[5] && c.op inside {OP_MUL, OP_MULL, OP_MLAL};
        c.rs = r[6] && c.op inside {OP_ALU, OP_ALU_PC};
        c.tk = (r[7] && c.op inside {[OP_ALU_PC:OP_LDM_PC]}) || c.op == OP_BLX_IMM;
        c.hit = r[8];
        c.pt = r[9];
        c.nr = {1'b0, r[13:10]} + 5'h01;
        c.mo = $random(seed);
        if (r[14]) c.mo[31:15] = {17{r[15]}};
        else if (r[16]) c.mo[31:27] = {5{r[17]}};
        c.dlo = {c.op inside {OP_ALU, OP_SAT, [OP_MUL:OP_MLAL_HH], OP_MOVE_FROM_ACC},
            r[21:18] % 4'hD};
        c.dhi = {c.op inside {OP_MULL, OP_MLAL, OP_MLAL_HH, OP_MOVE_FROM_ACC}, c.dlo[3:0] + 4'h1};
        c.sa = {r[22], r[26:23] % 4'hE};
        c.ss = {r[27], r[31:28] % 4'hE};
        c.sb = N;
        return c;
    endfunction : rnd

    // ==========================================================
    // Checking and transfer tasks
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk

    // Bounded wait for the issue pulse, counting stall cycles meanwhile
    task automatic waitIssue(output int t, output int ns);
        ns = 0;
        t = -1;
        for (int i = 0; i < 40 && t < 0; i++) begin
            @(posedge clock);
            #1;
            if (issue === 1'b1) t = cyc;
            else if (stall === 1'b1) ns++;
        end
        if (t < 0) begin
            chk("issue", 8'h01, 8'h00);
            t = cyc;
        end
    endtask : waitIssue

    // Producer then follower; idle long enough to drain the longest count
    task automatic pair(input iil_cand_t a, input iil_cand_t b);
        int t0, t1, ns, e;
        e = expDist(a, b);
        cur <= a;
        candValid <= 1'b1;
        waitIssue(t0, ns);
        chk("mispredict", {7'h00, misp(a)}, {7'h00, mispredict});
        chk("btbAllocate", {7'h00, a.op == OP_BRANCH && a.tk && !a.hit}, {7'h00, btbAllocate});
        cur <= b;
        waitIssue(t1, ns);
        candValid <= 1'b0;
        chk("distance", 8'(e), 8'(t1 - t0));
        chk("stallCycles", 8'(e - 1), 8'(ns));
        repeat (26) @(posedge clock);
        #1;
    endtask : pair

    task automatic give_verdict();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // Watchdog far beyond the roughly 3700 cycles the run needs
    initial begin
        #400000;
        n_mismatch++;
        give_verdict();
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clock);
        #1;
        rst <= 1'b0;
        @(posedge clock);
        #1;
        chk("issue", 8'h00, {7'h00, issue});
        pair(brc(OP_BRANCH, 1'b1, 1'b1, 1'b1), mk(OP_ALU));
        pair(brc(OP_BRANCH, 1'b1, 1'b1, 1'b0), mk(OP_ALU));
        pair(brc(OP_BRANCH, 1'b0, 1'b1, 1'b1), mk(OP_ALU));
        pair(brc(OP_BRANCH, 1'b1), mk(OP_ALU));
        pair(brc(OP_BX, 1'b0), mk(OP_ALU));
        pair(brc(OP_BX, 1'b1), mk(OP_ALU));
        pair(brc(OP_BLX_IMM, 1'b1), mk(OP_ALU));
        pair(brc(OP_ALU_PC, 1'b1), mk(OP_ALU));
        pair(brc(OP_ALU_PC, 1'b0), mk(OP_ALU));
        pair(brc(OP_LDR_PC, 1'b1), mk(OP_ALU));
        pair(brc(OP_LDR_PC, 1'b0), mk(OP_ALU));
        pair(brc(OP_LDM_PC, 1'b1, 1'b0, 1'b0, 5'h10), mk(OP_ALU));
        pair(brc(OP_LDM_PC, 1'b1, 1'b0, 1'b0, 5'h03), mk(OP_ALU));
        pair(brc(OP_LDM_PC, 1'b1, 1'b0, 1'b0, 5'h05), mk(OP_ALU));
        pair(brc(OP_LDM_PC, 1'b0), mk(OP_ALU));
        pair(mk(OP_ALU, R3, N, N, 1'b1), mk(OP_ALU, N, R3));
        pair(mk(OP_ALU, R3), mk(OP_ALU, N, N, R3));
        pair(mk(OP_SAT, R3), mk(OP_ALU, N, R3));
        pair(mk(OP_SAT, R3), mk(OP_SAT, N, N, R3));
        // Operand class edges for each multiply family
        for (int i = 0; i < 5; i++) begin
            pair(mk(OP_MUL, R4, N, N, 1'b0, mops[i]), mk(OP_ALU, N, R4));
            pair(mk(OP_MUL, N, N, N, 1'b0, mops[i]), mk(OP_MUL));
            pair(mk(OP_MUL, R4, N, N, 1'b0, mops[i], 1'b1), mk(OP_ALU));
            pair(mk(OP_MLAL, R4, N, N, 1'b0, mops[i], 1'b0, R5), mk(OP_ALU, N, R5));
            pair(mk(OP_MULL, R4, N, N, 1'b0, mops[i], 1'b1, R5), mk(OP_MUL, N, R5));
            pair(mk(OP_ACC_MUL, N, N, N, 1'b0, mops[i]), mk(OP_MOVE_FROM_ACC));
            pair(mk(OP_ACC_MUL, N, N, N, 1'b0, mops[i]), mk(OP_ALU));
        end
        pair(mk(OP_MUL_WH, R4), mk(OP_ALU, N, R4));
        pair(mk(OP_MLAL_HH, R4, N, N, 1'b0, 32'h0, 1'b0, R5), mk(OP_ALU, N, N, R5));
        pair(mk(OP_MUL_HH, R4), mk(OP_MUL_HH));
        pair(mk(OP_ACC_MUL_PH), mk(OP_MOVE_FROM_ACC));
        pair(mk(OP_ACC_MUL_HH), mk(OP_ACC_MUL));
        pair(mk(OP_MOVE_TO_ACC), mk(OP_MOVE_FROM_ACC));
        pair(mk(OP_MOVE_FROM_ACC, R6, N, N, 1'b0, 32'h0, 1'b0, R7), mk(OP_ALU, N, N, R7));
        // Reset in mid-run with a candidate waiting
        candValid <= 1'b1;
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk("issue", 8'h00, {7'h00, issue});
        chk("stall", 8'h00, {7'h00, stall});
        rst <= 1'b0;
        candValid <= 1'b0;
        @(posedge clock);
        #1;
        // Random pairs, tied through the shift operand or the B source whenever the producer has a valid low destination
        for (int i = 0; i < 60; i++) begin
            ca = rnd();
            cb = rnd();
            if (cb.sa[4]) cb.ss = ca.dlo;
            else cb.sb = ca.dlo;
            pair(ca, cb);
        end
        give_verdict();
    end
endmodule : iil_issue_interlock_test
`default_nettype wire
